// ==== design/dpmc_device.sv ====
// device end: sleep, partial/normal and inversion command handling
// Functional notes
// - sleep-entry command puts device asleep
// - sleep halts pump, oscillator, scanning
// - sleep keeps interface alive, memory kept
// - sleep-entry while asleep is ignored
// - host waits 5 ms after sleep entry
// - host waits 120 ms exit before entry
// - host keeps video syncs two frames
// - sleep exit re-enables stopped blocks
// - host starts syncs two frames before exit
// - host waits 5 ms after sleep exit
// - sleep exit reloads factory defaults
// - sleep exit while awake only reruns the diagnostic
// - sleep exit runs self-diagnostic
// - partial entry enters partial mode
// - partial entry while partial is ignored
// - normal entry clears partial and scrolling
// - host keeps syncs after partial entry
// - host starts syncs before normal entry
// - normal entry while normal is ignored
// - invert exit stops inversion only
// - invert exit ignored when not inverting
// - reset: asleep, normal, not inverting
// - diagnostic read: bit7 load, bit6 function
//
// The placing of the registers and the plain strobed port are this design's own decisions.
module dpmc_device
  import dpmc_pkg::*;
#(
  parameter logic REG_LOAD_OK = 1'b1,
  parameter logic FUNC_OK     = 1'b1
) (
  // clock and reset
  input  wire logic CLK,
  input  wire logic ARST_N,
  input  wire logic SOFT_RESET,
  // command bus
  dpmc_if.device    bus,
  // panel-side state
  output logic      SLEEPING,
  output logic      PUMP_EN,
  output logic      OSC_EN,
  output logic      SCAN_EN,
  output logic      PARTIAL_MODE,
  output logic      SCROLL_ON,
  output logic      INVERT_ON,
  output logic      DEFAULTS_LOAD,
  output logic      DIAG_BUSY,
  input  wire logic SET_SCROLL,
  input  wire logic SET_INVERT
);
  // ==========================================================
  // input synchronisers
  logic [2:0] wr_sync_reg;
  logic [2:0] rd_sync_reg;
  logic [1:0] dc_sync_reg;
  logic [7:0] d0_reg;
  logic [7:0] d1_reg;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_sync_reg <= 3'h7;
      rd_sync_reg <= 3'h7;
      dc_sync_reg <= 2'h3;
      d0_reg      <= 8'h00;
      d1_reg      <= 8'h00;
    end else begin
      wr_sync_reg <= {wr_sync_reg[1:0], bus.write_strobe_n};
      rd_sync_reg <= {rd_sync_reg[1:0], bus.read_strobe_n};
      dc_sync_reg <= {dc_sync_reg[0], bus.data_command_select};
      d0_reg      <= bus.host_data;
      d1_reg      <= d0_reg;
    end
  end
  // byte taken on rising write strobe (stage 2 vs stage 3)
  logic wr_rise;
  logic cmd_take;
  logic [7:0] cmd_byte;
  assign wr_rise  = wr_sync_reg[1] & ~wr_sync_reg[2];
  assign cmd_take = wr_rise & ~dc_sync_reg[1];
  assign cmd_byte = d1_reg;

  // ==========================================================
  // state flags
  logic sleep_reg;
  logic partial_reg;
  logic scroll_reg;
  logic invert_reg;
  logic soft_rst;
  assign soft_rst = SOFT_RESET;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sleep_reg <= 1'b1;
    end else if (soft_rst) begin
      sleep_reg <= 1'b1;
    end else if (cmd_take && cmd_byte == CMD_SLEEP_ENTER) begin
      sleep_reg <= 1'b1;
    end else if (cmd_take && cmd_byte == CMD_SLEEP_EXIT) begin
      sleep_reg <= 1'b0;
    end
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      partial_reg <= 1'b0;
    end else if (soft_rst) begin
      partial_reg <= 1'b0;
    end else if (cmd_take && cmd_byte == CMD_PARTIAL_ON) begin
      partial_reg <= 1'b1;
    end else if (cmd_take && cmd_byte == CMD_NORMAL_ON) begin
      partial_reg <= 1'b0;
    end
  end
  // scroll is set elsewhere; normal entry turns it off
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scroll_reg <= 1'b0;
    end else if (soft_rst) begin
      scroll_reg <= 1'b0;
    end else if (SET_SCROLL) begin
      // set wins over a clear in the same cycle
      scroll_reg <= 1'b1;
    end else if (cmd_take && cmd_byte == CMD_NORMAL_ON) begin
      scroll_reg <= 1'b0;
    end
  end
  // invert exit touches only this flag
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      invert_reg <= 1'b0;
    end else if (soft_rst) begin
      invert_reg <= 1'b0;
    end else if (SET_INVERT) begin
      invert_reg <= 1'b1;
    end else if (cmd_take && cmd_byte == CMD_INVERT_OFF) begin
      invert_reg <= 1'b0;
    end else if (cmd_take && cmd_byte == CMD_INVERT_ON) begin
      invert_reg <= 1'b1;
    end
  end

  // ==========================================================
  // wake sequence: default reload and diagnostic start in the same cycle
  logic wake;
  logic load_reg;
  logic [2:0] diag_cnt_reg;
  logic diag_done_reg;
  assign wake = cmd_take && cmd_byte == CMD_SLEEP_EXIT && sleep_reg;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= wake;
    end
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      diag_cnt_reg <= 3'h0;
    end else if (soft_rst) begin
      diag_cnt_reg <= 3'h0;
    end else if (cmd_take && cmd_byte == CMD_SLEEP_EXIT) begin
      diag_cnt_reg <= 3'(DIAG_CYC);
    end else if (diag_cnt_reg != 3'h0) begin
      diag_cnt_reg <= diag_cnt_reg - 3'h1;
    end
  end
  // result cleared at sleep entry, valid once diagnostic ends
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      diag_done_reg <= 1'b0;
    end else if (soft_rst || (cmd_take && cmd_byte == CMD_SLEEP_ENTER)) begin
      diag_done_reg <= 1'b0;
    end else if (diag_cnt_reg == 3'h1) begin
      diag_done_reg <= 1'b1;
    end
  end

  // ==========================================================
  // status read: command 0Fh, then dummy, then result byte
  logic       rd_fall;
  logic [1:0] rd_phase_reg;
  logic       diag_sel_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] diag_byte;
  assign rd_fall = ~rd_sync_reg[1] & rd_sync_reg[2];
  always_comb begin
    diag_byte = 8'h00;
    diag_byte[DIAG_REG_LOAD_BIT] = diag_done_reg & REG_LOAD_OK;
    diag_byte[DIAG_FUNC_BIT]     = diag_done_reg & FUNC_OK;
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      diag_sel_reg <= 1'b0;
      rd_phase_reg <= 2'h0;
    end else if (cmd_take) begin
      diag_sel_reg <= (cmd_byte == CMD_GET_DIAG);
      rd_phase_reg <= 2'h0;
    end else if (rd_fall && rd_phase_reg != 2'h2) begin
      rd_phase_reg <= rd_phase_reg + 2'h1;
    end
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_data_reg <= 8'h00;
    end else if (rd_fall) begin
      rd_data_reg <= (diag_sel_reg && rd_phase_reg == 2'h1) ?
                     diag_byte : 8'h00;
    end
  end
  // interface keeps working in sleep; nothing here is gated
  assign bus.dev_data    = rd_data_reg;
  assign bus.dev_data_oe = ~rd_sync_reg[1] & dc_sync_reg[1];

  // ==========================================================
  // outputs
  assign SLEEPING      = sleep_reg;
  assign PUMP_EN       = ~sleep_reg;
  assign OSC_EN        = ~sleep_reg;
  assign SCAN_EN       = ~sleep_reg;
  assign PARTIAL_MODE  = partial_reg;
  assign SCROLL_ON     = scroll_reg;
  assign INVERT_ON     = invert_reg;
  assign DEFAULTS_LOAD = load_reg;
  assign DIAG_BUSY     = diag_cnt_reg != 3'h0;
endmodule

// ==== design/dpmc_pkg.sv ====
// package: command codes, status bits and timing for power/mode commands
package dpmc_pkg;
  // command bytes (data_command_select low)
  localparam logic [7:0] CMD_SLEEP_ENTER  = 8'h10;
  localparam logic [7:0] CMD_SLEEP_EXIT   = 8'h11;
  localparam logic [7:0] CMD_PARTIAL_ON   = 8'h12;
  localparam logic [7:0] CMD_NORMAL_ON    = 8'h13;
  localparam logic [7:0] CMD_INVERT_OFF   = 8'h20;
  localparam logic [7:0] CMD_INVERT_ON    = 8'h21;
  localparam logic [7:0] CMD_GET_DIAG     = 8'h0F;
  // diagnostic status bit positions
  localparam int DIAG_REG_LOAD_BIT = 7;
  localparam int DIAG_FUNC_BIT     = 6;
  // timing
  localparam int CLK_HZ            = 50_000_000;
  localparam int SLEEP_WAIT_MS     = 5;
  localparam int EXIT_TO_ENTER_MS  = 120;
  localparam int SLEEP_WAIT_CYC    = SLEEP_WAIT_MS * (CLK_HZ / 1000);
  localparam int EXIT_TO_ENTER_CYC = EXIT_TO_ENTER_MS * (CLK_HZ / 1000);
  localparam int DIAG_CYC          = 4;
  localparam int STROBE_LOW_CYC    = 2;
  // host register offsets
  localparam logic [3:0] HREG_CMD    = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h4;
  localparam logic [3:0] HREG_DIAG   = 4'h8;
  localparam logic [3:0] HREG_CFG    = 4'hC;
endpackage

// ==== design/dpmc_if.sv ====
// interface: parallel command bus between host and display device
interface dpmc_if;
  logic       data_command_select;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic [7:0] host_data;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic [7:0] bus_level;
  assign bus_level = dev_data_oe ? dev_data : host_data;
  modport device (input data_command_select, write_strobe_n,
                  read_strobe_n, host_data,
                  output dev_data, dev_data_oe);
  modport host (output data_command_select, write_strobe_n,
                read_strobe_n, host_data,
                input dev_data, dev_data_oe);
endinterface

// ==== design/dpmc_host.sv ====
// host end: issues command bytes and keeps the waiting obligations
module dpmc_host
  import dpmc_pkg::*;
#(
  parameter int SLEEP_WAIT  = SLEEP_WAIT_CYC,
  parameter int ENTER_GUARD = EXIT_TO_ENTER_CYC
) (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  // register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // command bus
  dpmc_if.host            bus
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_SETUP = 4'b0010,
    S_STROBE = 4'b0100,
    S_WAIT = 4'b1000
  } dpmc_hstate_t;

  dpmc_hstate_t state_reg;
  logic [7:0]   cmd_reg;
  logic         pend_reg;
  logic [1:0]   low_cnt_reg;
  logic [31:0]  wait_cnt_reg;
  logic [31:0]  guard_cnt_reg;
  logic         video_reg;
  logic         is_enter;
  logic         guard_hold;
  logic         xfer_rd_reg;
  logic [1:0]   rd_left_reg;
  logic [7:0]   diag_reg;

  // ==========================================================
  // command capture; refused while pending or sequencer not idle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmd_reg  <= 8'h00;
      pend_reg <= 1'b0;
    end else if (WR && ADDR == HREG_CMD && !pend_reg &&
                 state_reg == S_IDLE) begin
      cmd_reg  <= WDATA;
      pend_reg <= 1'b1;
    end else if (state_reg == S_IDLE && pend_reg && !guard_hold &&
                 rd_left_reg == 2'h0) begin
      pend_reg <= 1'b0;
    end
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      video_reg <= 1'b0;
    end else if (WR && ADDR == HREG_CFG) begin
      video_reg <= WDATA[0];
    end
  end

  assign is_enter   = cmd_reg == CMD_SLEEP_ENTER;
  assign guard_hold = is_enter && guard_cnt_reg != 32'h0;

  // ==========================================================
  // bus sequencer
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg   <= S_IDLE;
      low_cnt_reg <= 2'h0;
      xfer_rd_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (rd_left_reg != 2'h0) begin
            state_reg   <= S_SETUP;
            xfer_rd_reg <= 1'b1;
          end else if (pend_reg && !guard_hold) begin
            state_reg   <= S_SETUP;
            xfer_rd_reg <= 1'b0;
          end
        end
        S_SETUP: begin
          state_reg   <= S_STROBE;
          // reads stay low longer: device data lags its synchronisers
          low_cnt_reg <= xfer_rd_reg ? 2'(STROBE_LOW_CYC + 1) :
                                       2'(STROBE_LOW_CYC);
        end
        S_STROBE: begin
          if (low_cnt_reg == 2'h0) begin
            state_reg <= S_WAIT;
          end else begin
            low_cnt_reg <= low_cnt_reg - 2'h1;
          end
        end
        S_WAIT: begin
          if (wait_cnt_reg == 32'h0) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
  // 5 ms after sleep entry or exit, else brief gap
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wait_cnt_reg <= 32'h0;
    end else if (state_reg == S_STROBE && low_cnt_reg == 2'h0) begin
      wait_cnt_reg <= (!xfer_rd_reg && (cmd_reg == CMD_SLEEP_ENTER ||
                                        cmd_reg == CMD_SLEEP_EXIT)) ?
                      32'(SLEEP_WAIT) : 32'(STROBE_LOW_CYC);
    end else if (wait_cnt_reg != 32'h0) begin
      wait_cnt_reg <= wait_cnt_reg - 32'h1;
    end
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      guard_cnt_reg <= 32'h0;
    end else if (state_reg == S_STROBE && low_cnt_reg == 2'h0 &&
                 !xfer_rd_reg && cmd_reg == CMD_SLEEP_EXIT) begin
      guard_cnt_reg <= 32'(ENTER_GUARD);
    end else if (guard_cnt_reg != 32'h0) begin
      guard_cnt_reg <= guard_cnt_reg - 32'h1;
    end
  end

  // diagnostic read after 0Fh: dummy byte, then result byte
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_left_reg <= 2'h0;
      diag_reg    <= 8'h00;
    end else if (state_reg == S_STROBE && low_cnt_reg == 2'h0) begin
      if (xfer_rd_reg) begin
        rd_left_reg <= rd_left_reg - 2'h1;
        if (rd_left_reg == 2'h1) begin
          diag_reg <= bus.dev_data;
        end
      end else if (cmd_reg == CMD_GET_DIAG) begin
        rd_left_reg <= 2'h2;
      end
    end
  end

  assign bus.data_command_select = xfer_rd_reg;
  assign bus.read_strobe_n       = !(state_reg == S_STROBE && xfer_rd_reg);
  assign bus.write_strobe_n      = !(state_reg == S_STROBE && !xfer_rd_reg);
  assign bus.host_data           = cmd_reg;

  // ==========================================================
  // register reads; video flag is informational
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        HREG_STATUS: RDATA <= {5'h00, guard_hold,
                               state_reg != S_IDLE || rd_left_reg != 2'h0,
                               pend_reg};
        HREG_CMD:    RDATA <= cmd_reg;
        HREG_DIAG:   RDATA <= diag_reg;
        HREG_CFG:    RDATA <= {7'h00, video_reg};
        default:     RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end
endmodule

// ==== verification/dpmc_checker_sva.sv ====
// checker: command-bus timing and mode-flag properties for both ends
module dpmc_checker_sva
  import dpmc_pkg::*;
#(
  parameter int SLEEP_WAIT  = 20,
  parameter int ENTER_GUARD = 50
) (
  // clock and reset
  input wire logic       CLK,
  input wire logic       ARST_N,
  input wire logic       SOFT_RESET,
  // command bus
  input wire logic       data_command_select,
  input wire logic       write_strobe_n,
  input wire logic [7:0] host_data,
  // device state
  input wire logic       SLEEPING,
  input wire logic       PUMP_EN,
  input wire logic       OSC_EN,
  input wire logic       SCAN_EN,
  input wire logic       PARTIAL_MODE,
  input wire logic       SCROLL_ON,
  input wire logic       INVERT_ON,
  input wire logic       DEFAULTS_LOAD,
  input wire logic       DIAG_BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // byte capture and gap counters
  logic        wr_q;
  logic        take;
  logic        fall;
  logic [7:0]  byte_q;
  logic [15:0] since_slp;
  logic [15:0] since_exit;
  // byte is latched while the strobe is low, rise commits it
  assign take = write_strobe_n & ~wr_q & ~data_command_select;
  assign fall = ~write_strobe_n & wr_q;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_q       <= 1'b1;
      byte_q     <= 8'h00;
      since_slp  <= 16'hFFFF;
      since_exit <= 16'hFFFF;
    end else begin
      wr_q <= write_strobe_n;
      if (!write_strobe_n) byte_q <= host_data;
      since_slp <= (take && byte_q[7:1] == CMD_SLEEP_ENTER[7:1]) ? 16'h0000
                 : (since_slp == 16'hFFFF) ? since_slp : since_slp + 16'h0001;
      since_exit <= (take && byte_q == CMD_SLEEP_EXIT) ? 16'h0000
                  : (since_exit == 16'hFFFF) ? since_exit
                  : since_exit + 16'h0001;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  AST_SLEEP_ENTER:
    assert property (take && byte_q == CMD_SLEEP_ENTER |-> ##[1:6] SLEEPING)
      else $error("sleep entry did not reach sleep");
  AST_HALT_IN_SLEEP:
    assert property ({PUMP_EN, OSC_EN, SCAN_EN} == {3{!SLEEPING}})
      else $error("block enables disagree with sleep flag");
  AST_CMD_GAP:
    assert property (fall |-> since_slp >= SLEEP_WAIT - 2)
      else $error("strobe too soon after sleep command");
  AST_ENTER_GUARD:
    assert property (take && byte_q == CMD_SLEEP_ENTER
      |-> since_exit >= ENTER_GUARD - 2)
      else $error("sleep entry too soon after sleep exit");
  AST_WAKE_DEFAULTS:
    assert property ($fell(SLEEPING) |-> ##[0:1] DEFAULTS_LOAD)
      else $error("no default reload on wake");
  AST_WAKE_DIAG:
    assert property (take && byte_q == CMD_SLEEP_EXIT && SLEEPING
      |-> ##[1:8] DIAG_BUSY)
      else $error("no diagnostic run on wake");
  AST_PARTIAL_ON:
    assert property (take && byte_q == CMD_PARTIAL_ON
      |-> ##[1:6] PARTIAL_MODE)
      else $error("partial entry not applied");
  AST_NORMAL_ON:
    assert property (take && byte_q == CMD_NORMAL_ON
      |-> ##[1:6] !(PARTIAL_MODE || SCROLL_ON))
      else $error("normal entry left partial or scroll on");
  AST_INVERT_OFF:
    assert property (take && byte_q == CMD_INVERT_OFF |-> ##[1:6] !INVERT_ON)
      else $error("invert exit not applied");
  AST_SOFT_RESET:
    assert property (SOFT_RESET
      |=> SLEEPING && !PARTIAL_MODE && !INVERT_ON && !SCROLL_ON)
      else $error("soft reset state wrong");
  cover property ($fell(SLEEPING));
  cover property (take && byte_q == CMD_SLEEP_ENTER);
  cover property ($rose(PARTIAL_MODE));
endmodule

// ==== verification/tb_display_power_mode_commands.sv ====
// testbench: host register port driving the device over the command bus
module tb_display_power_mode_commands
  import dpmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SW_CYC = 20;
  localparam int EG_CYC = 50;
  // ==========================================================
  // signals
  logic       clk        = 1'b0;
  logic       arst_n     = 1'b0;
  logic       soft_reset = 1'b0;
  logic       set_scroll = 1'b0;
  logic       set_invert = 1'b0;
  logic [3:0] addr       = 4'h0;
  logic [7:0] wdata      = 8'h00;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic [7:0] rdata;
  logic       sleeping, pump_en, osc_en, scan_en, partial_mode;
  logic       scroll_on, invert_on, defaults_load, diag_busy;
  logic [7:0] flags;
  logic [7:0] r;
  int         bad_count  = 0;
  int         num_checks = 0;
  int         cyc        = 0;
  assign flags = {1'b0, sleeping, partial_mode, scroll_on,
                  pump_en, osc_en, scan_en, invert_on};
  always #10 clk = ~clk;
  // ==========================================================
  // design ends and checker
  dpmc_if bus_if ();
  dpmc_device i_dpmc_device (
    .CLK(clk), .ARST_N(arst_n), .SOFT_RESET(soft_reset), .bus(bus_if),
    .SLEEPING(sleeping), .PUMP_EN(pump_en), .OSC_EN(osc_en),
    .SCAN_EN(scan_en), .PARTIAL_MODE(partial_mode), .SCROLL_ON(scroll_on),
    .INVERT_ON(invert_on), .DEFAULTS_LOAD(defaults_load),
    .DIAG_BUSY(diag_busy), .SET_SCROLL(set_scroll), .SET_INVERT(set_invert));
  dpmc_host #(.SLEEP_WAIT(SW_CYC), .ENTER_GUARD(EG_CYC)) i_dpmc_host (
    .CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .bus(bus_if));
  dpmc_checker_sva #(.SLEEP_WAIT(SW_CYC), .ENTER_GUARD(EG_CYC)) i_chk (
    .CLK(clk), .ARST_N(arst_n), .SOFT_RESET(soft_reset),
    .data_command_select(bus_if.data_command_select),
    .write_strobe_n(bus_if.write_strobe_n), .host_data(bus_if.host_data),
    .SLEEPING(sleeping), .PUMP_EN(pump_en), .OSC_EN(osc_en),
    .SCAN_EN(scan_en), .PARTIAL_MODE(partial_mode), .SCROLL_ON(scroll_on),
    .INVERT_ON(invert_on), .DEFAULTS_LOAD(defaults_load),
    .DIAG_BUSY(diag_busy));
  // ==========================================================
  // tasks
  task automatic end_sim();
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // poll until nothing pending or busy, then let the sync flops settle
  task automatic wait_idle();
    logic [7:0] s;
    s = 8'hFF;
    for (int i = 0; i < 400 && s[1:0] != 2'b00; i++)
      rd_reg(HREG_STATUS, s);
    chk("idle", 8'h00, s & 8'h03);
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic do_cmd(input logic [7:0] c, input logic [7:0] exp);
    wr_reg(HREG_CMD, c);
    wait_idle();
    chk("flags", exp, flags);
  endtask
  // ==========================================================
  // timeout and main sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk("flags", 8'h40, flags);
    do_cmd(CMD_GET_DIAG, 8'h40);
    rd_reg(HREG_DIAG, r);
    chk("diag", 8'h00, r);
    do_cmd(CMD_SLEEP_ENTER, 8'h40);
    do_cmd(CMD_SLEEP_EXIT, 8'h0E);
    do_cmd(CMD_GET_DIAG, 8'h0E);
    rd_reg(HREG_DIAG, r);
    chk("diag", 8'hC0, r);
    do_cmd(CMD_SLEEP_EXIT, 8'h0E);
    @(posedge clk) set_scroll <= 1'b1;
    @(posedge clk) set_scroll <= 1'b0;
    do_cmd(CMD_PARTIAL_ON, 8'h3E);
    do_cmd(CMD_PARTIAL_ON, 8'h3E);
    do_cmd(CMD_NORMAL_ON, 8'h0E);
    do_cmd(CMD_NORMAL_ON, 8'h0E);
    do_cmd(CMD_INVERT_ON, 8'h0F);
    do_cmd(CMD_INVERT_OFF, 8'h0E);
    do_cmd(CMD_INVERT_OFF, 8'h0E);
    // sleep entry right after exit must be held by the guard
    do_cmd(CMD_SLEEP_EXIT, 8'h0E);
    wr_reg(HREG_CMD, CMD_SLEEP_ENTER);
    rd_reg(HREG_STATUS, r);
    chk("status", 8'h05, r & 8'h05);
    wr_reg(HREG_CMD, CMD_PARTIAL_ON);
    wait_idle();
    chk("flags", 8'h40, flags);
    do_cmd(CMD_GET_DIAG, 8'h40);
    rd_reg(HREG_DIAG, r);
    chk("diag", 8'h00, r);
    do_cmd(CMD_SLEEP_EXIT, 8'h0E);
    do_cmd(CMD_PARTIAL_ON, 8'h2E);
    @(posedge clk) set_invert <= 1'b1;
    @(posedge clk) set_invert <= 1'b0;
    @(posedge clk) soft_reset <= 1'b1;
    @(posedge clk) soft_reset <= 1'b0;
    repeat (2) @(negedge clk);
    chk("flags", 8'h40, flags);
    wr_reg(HREG_CFG, 8'h01);
    rd_reg(HREG_CFG, r);
    chk("cfg", 8'h01, r);
    rd_reg(4'h2, r);
    chk("unmapped", 8'h00, r);
    end_sim();
  end
endmodule
